// File: pkg/dsad_pkg.sv
// Constants for the data space address decoder
package dsad_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int WORDS_SMALL = 512;
    localparam int WORDS_LARGE = 1024;
    localparam int WORDS_MAX = 1024;
    localparam int WIDX_W = 10;
    localparam int MSB_BIT = 15;
    localparam int LANE_BIT = 0;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [ADDR_W-1:0] ZERO_ADDR = 16'h0000;
endpackage

// File: src/dsad_decoder.sv
// Data space address decoder with implemented word RAM and program window port
// Contract
// R1: Data space is separate, 16-bit, linear
// R2: Independent read and write address ports
// R3: 16-bit byte addresses, 64 Kbytes total
// R4: Top address bit clear selects data RAM
// R5: Top address bit set selects program window
// R6: Implemented words parameter, 512 or 1024
// R7: Unimplemented reads return all zeros
// R8: Storage in aligned 16-bit words
// R9: Even byte is low, odd is high
// R10: Byte writes touch only selected lane
// R11: Program window accesses forwarded to port; only reads are, writes with the top bit set are dropped
`timescale 1ns/10ps
`default_nettype none
module dsad_decoder #(
    parameter int IMPL_WORDS = dsad_pkg::WORDS_LARGE
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    input wire logic I_RD_EN,
    input wire logic [dsad_pkg::ADDR_W-1:0] I_RD_EFFECTIVE_ADDRESS,
    input wire logic I_RD_BYTE,
    input wire logic I_WR_EN,
    input wire logic [dsad_pkg::ADDR_W-1:0] I_WR_EFFECTIVE_ADDRESS,
    input wire logic I_WR_BYTE,
    input wire logic [dsad_pkg::DATA_W-1:0] I_WR_DATA,
    input wire logic [dsad_pkg::DATA_W-1:0] I_PSW_RD_DATA,
    output logic [dsad_pkg::DATA_W-1:0] O_RD_DATA,
    output logic O_RD_VALID,
    output logic O_PSW_RD_EN,
    output logic [dsad_pkg::ADDR_W-1:0] O_PSW_RD_ADDRESS,
    output logic O_PSW_RD_BYTE
);
    import dsad_pkg::*;

    // Word array; writes beyond IMPL_WORDS never reach it
    logic [DATA_W-1:0] mem [WORDS_MAX]; // see R1 // see R8
    logic [DATA_W-1:0] rd_word_r;
    logic rd_hit_r;
    logic rd_psw_r;
    logic rd_miss_r;
    logic rd_byte_r;
    logic rd_lane_r;
    logic [DATA_W-1:0] rd_data_nxt;

    // Address split, each unit decoded on its own
    wire rd_in_ram = (I_RD_EFFECTIVE_ADDRESS[MSB_BIT] == 1'b0); // see R2 // see R4
    wire rd_in_psw = I_RD_EFFECTIVE_ADDRESS[MSB_BIT]; // see R5
    wire wr_in_ram = (I_WR_EFFECTIVE_ADDRESS[MSB_BIT] == 1'b0); // see R2 // see R4
    wire [ADDR_W-2:0] rd_word_full = I_RD_EFFECTIVE_ADDRESS[ADDR_W-1:LANE_BIT+1]; // see R3
    wire [ADDR_W-2:0] wr_word_full = I_WR_EFFECTIVE_ADDRESS[ADDR_W-1:LANE_BIT+1]; // see R3
    // Full word index is compared, so words past the array cannot alias onto it
    wire rd_impl = rd_in_ram && (rd_word_full < (ADDR_W-1)'(IMPL_WORDS)); // see R6
    wire wr_impl = wr_in_ram && (wr_word_full < (ADDR_W-1)'(IMPL_WORDS)); // see R6
    wire [WIDX_W-1:0] rd_idx = rd_word_full[WIDX_W-1:0];
    wire [WIDX_W-1:0] wr_idx = wr_word_full[WIDX_W-1:0];
    wire rd_lane = I_RD_EFFECTIVE_ADDRESS[LANE_BIT]; // see R9
    wire wr_lane = I_WR_EFFECTIVE_ADDRESS[LANE_BIT]; // see R9

    // Every read falls in exactly one class, so valid always follows two edges later
    wire rd_ram_req = I_RD_EN && rd_impl;
    wire rd_psw_req = I_RD_EN && rd_in_psw; // see R11
    wire rd_miss_req = I_RD_EN && !rd_impl && !rd_in_psw; // see R7
    wire wr_lo = I_WR_EN && wr_impl && (!I_WR_BYTE || !wr_lane); // see R9 // see R10
    wire wr_hi = I_WR_EN && wr_impl && (!I_WR_BYTE || wr_lane); // see R9 // see R10

    // Byte write data arrives in the low byte of I_WR_DATA
    wire [BYTE_W-1:0] wr_lo_byte = I_WR_DATA[BYTE_W-1:0];
    wire [BYTE_W-1:0] wr_hi_byte = I_WR_BYTE ? I_WR_DATA[BYTE_W-1:0] : I_WR_DATA[DATA_W-1:BYTE_W];
    wire [BYTE_W-1:0] rd_sel_byte = rd_lane_r ? rd_word_r[DATA_W-1:BYTE_W] : rd_word_r[BYTE_W-1:0]; // see R9
    // Window path aligns its own byte, so only its low byte is kept
    wire [BYTE_W-1:0] psw_sel_byte = I_PSW_RD_DATA[BYTE_W-1:0];
    wire [DATA_W-1:0] rd_ram_data = rd_byte_r ? {ZERO_BYTE, rd_sel_byte} : rd_word_r;
    wire [DATA_W-1:0] rd_psw_data = rd_byte_r ? {ZERO_BYTE, psw_sel_byte} : I_PSW_RD_DATA;

    // Memory has no reset so it maps onto plain RAM; a read beside a write sees the old word
    always_ff @(posedge I_SYS_CLK)
    begin
        if (wr_lo)
            mem[wr_idx][BYTE_W-1:0] <= wr_lo_byte; // see R10
        if (wr_hi)
            mem[wr_idx][DATA_W-1:BYTE_W] <= wr_hi_byte; // see R10
        rd_word_r <= mem[rd_idx];
    end

    // Read pipeline, one stage behind the request
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
        begin
            rd_hit_r <= 1'b0;
            rd_psw_r <= 1'b0;
            rd_miss_r <= 1'b0;
            rd_byte_r <= 1'b0;
            rd_lane_r <= 1'b0;
        end
        else
        begin
            rd_hit_r <= rd_ram_req;
            rd_psw_r <= rd_psw_req;
            rd_miss_r <= rd_miss_req;
            rd_byte_r <= I_RD_BYTE;
            rd_lane_r <= rd_lane;
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
        begin
            O_PSW_RD_EN <= 1'b0;
            O_PSW_RD_ADDRESS <= ZERO_ADDR;
            O_PSW_RD_BYTE <= 1'b0;
        end
        else
        begin
            O_PSW_RD_EN <= rd_psw_req; // see R11
            O_PSW_RD_ADDRESS <= I_RD_EFFECTIVE_ADDRESS; // see R11
            O_PSW_RD_BYTE <= I_RD_BYTE; // see R11
        end
    end

    always_comb
    begin
        rd_data_nxt = ZERO_WORD; // see R7
        if (rd_hit_r)
            rd_data_nxt = rd_ram_data;
        else if (rd_psw_r)
            rd_data_nxt = rd_psw_data; // see R11
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
        begin
            O_RD_VALID <= 1'b0;
            O_RD_DATA <= ZERO_WORD;
        end
        else
        begin
            O_RD_VALID <= rd_hit_r || rd_psw_r || rd_miss_r; // see R2
            O_RD_DATA <= rd_data_nxt;
        end
    end

    a_unimpl_reads_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R7
        I_RD_EN && !rd_impl && !rd_in_psw
        |-> ##2 (O_RD_VALID && O_RD_DATA == ZERO_WORD))
        else $error("unimplemented read not zero");

    a_idle_data_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R7
        !O_RD_VALID
        |-> O_RD_DATA == ZERO_WORD)
        else $error("read data not zero while idle");

    a_window_forward: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R11
        I_RD_EN && rd_in_psw
        |=> (O_PSW_RD_EN && O_PSW_RD_ADDRESS == $past(I_RD_EFFECTIVE_ADDRESS)))
        else $error("window access not forwarded");

    a_window_byte_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R11
        I_RD_EN && rd_in_psw
        |=> O_PSW_RD_BYTE == $past(I_RD_BYTE))
        else $error("window byte flag not forwarded");

    a_window_word_data: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R11
        I_RD_EN && rd_in_psw && !I_RD_BYTE
        |-> ##2 (O_RD_VALID && O_RD_DATA == $past(I_PSW_RD_DATA)))
        else $error("window word data not returned");

    a_window_byte_data: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R9
        I_RD_EN && rd_in_psw && I_RD_BYTE
        |-> ##2 (O_RD_VALID && O_RD_DATA == {ZERO_BYTE, $past(I_PSW_RD_DATA[BYTE_W-1:0])}))
        else $error("window byte data not returned");

    a_ram_no_window: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R4
        I_RD_EN && rd_in_ram
        |=> !O_PSW_RD_EN)
        else $error("low half reached window port");

    a_window_only_read: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R2
        !I_RD_EN
        |=> !O_PSW_RD_EN)
        else $error("window port raised without read");

    a_read_valid_lat: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R2
        !I_RD_EN ##1 !I_RD_EN
        |=> !O_RD_VALID)
        else $error("valid without read");

    a_read_valid_each: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R2
        I_RD_EN
        |-> ##2 O_RD_VALID)
        else $error("read not answered");

    a_byte_read_high: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R9
        I_RD_EN && I_RD_BYTE
        |-> ##2 (O_RD_DATA[DATA_W-1:BYTE_W] == ZERO_BYTE))
        else $error("byte read upper lane not zero");

    a_ram_word_data: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R8
        I_RD_EN && rd_impl && !I_RD_BYTE
        |-> ##2 (O_RD_DATA === $past(mem[rd_idx], 2)))
        else $error("word read data wrong");

    a_ram_byte_data: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R9
        I_RD_EN && rd_impl && I_RD_BYTE
        |-> ##2 (O_RD_DATA[BYTE_W-1:0] === ($past(rd_lane, 2) ? $past(mem[rd_idx][DATA_W-1:BYTE_W], 2)
            : $past(mem[rd_idx][BYTE_W-1:0], 2))))
        else $error("byte read lane wrong");

    a_byte_write_lane: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R10
        I_WR_EN && I_WR_BYTE && wr_impl && !wr_lane
        |=> mem[$past(wr_idx)] === {$past(mem[wr_idx][DATA_W-1:BYTE_W]), $past(I_WR_DATA[BYTE_W-1:0])})
        else $error("low byte write disturbed word");

    a_byte_write_high: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R10
        I_WR_EN && I_WR_BYTE && wr_impl && wr_lane
        |=> mem[$past(wr_idx)] === {$past(I_WR_DATA[BYTE_W-1:0]), $past(mem[wr_idx][BYTE_W-1:0])})
        else $error("high byte write disturbed word");

    a_window_lane_msb: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R5
        O_PSW_RD_EN
        |-> O_PSW_RD_ADDRESS[MSB_BIT])
        else $error("window port got low half address");

    a_impl_bound: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R6
        I_WR_EN && !wr_impl
        |=> mem[$past(wr_idx)] === $past(mem[wr_idx]))
        else $error("write outside implemented range landed");

    a_impl_size: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) // see R6
        IMPL_WORDS == WORDS_SMALL || IMPL_WORDS == WORDS_LARGE)
        else $error("implemented size not a legal variant");
endmodule
`default_nettype wire

// File: dv/dsad_psw_model.sv
// Model of the program window read path
`timescale 1ns/10ps
`default_nettype none
module dsad_psw_model (
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [15:0] i_addr,
    output logic [15:0] o_data
);
    logic [15:0] junk_r = 16'h5A5A;
    // Idle data flips every cycle so a late sample never matches
    always_ff @(posedge i_clk) junk_r <= ~junk_r;
    // Answers in the same cycle as the forwarded request
    assign o_data = i_en ? (i_addr ^ 16'hA5C3) : junk_r;
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the data space decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    import dsad_pkg::*;
    logic I_SYS_CLK = 0, I_RESET_N = 0, re = 0, rb = 0, we = 0, wb = 0, rv, pe, pb;
    logic [15:0] ra = 0, wa = 0, wd = 0, pd, rd, pa;
    int n_mismatch = 0, checks_done = 0;
    always #50 I_SYS_CLK = ~I_SYS_CLK;
    dsad_decoder #(.IMPL_WORDS(WORDS_LARGE)) dut (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N),
        .I_RD_EN(re), .I_RD_EFFECTIVE_ADDRESS(ra), .I_RD_BYTE(rb), .I_WR_EN(we),
        .I_WR_EFFECTIVE_ADDRESS(wa), .I_WR_BYTE(wb), .I_WR_DATA(wd), .I_PSW_RD_DATA(pd),
        .O_RD_DATA(rd), .O_RD_VALID(rv), .O_PSW_RD_EN(pe), .O_PSW_RD_ADDRESS(pa), .O_PSW_RD_BYTE(pb));
    dsad_psw_model psw (.i_clk(I_SYS_CLK), .i_en(pe), .i_addr(pa), .o_data(pd));
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
        @(negedge I_SYS_CLK) {we, wa, wd, wb} = {1'b1, a, d, b};
        @(negedge I_SYS_CLK) we = 0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic b, input logic [15:0] e, input logic w);
        @(negedge I_SYS_CLK) {re, ra, rb} = {1'b1, a, b};
        @(negedge I_SYS_CLK) re = 0;
        `CHK("window", w, pe)
        if (w)
        begin
            `CHK("window addr", a, pa)
            `CHK("window byte", b, pb)
        end
        @(negedge I_SYS_CLK);
        `CHK("valid", 1'b1, rv)
        `CHK("data", e, rd)
        @(negedge I_SYS_CLK);
        `CHK("valid end", 1'b0, rv)
    endtask
    task automatic t_words;
        wr(16'h0000, 16'h1234, 0);
        wr(16'h07FE, 16'hBEEF, 0);
        rdc(16'h0000, 0, 16'h1234, 0);
        rdc(16'h07FF, 0, 16'hBEEF, 0);
    endtask
    task automatic t_lanes;
        wr(16'h0100, 16'hAAAA, 0);
        wr(16'h0101, 16'h0055, 1);
        wr(16'h0100, 16'h00C3, 1);
        rdc(16'h0100, 0, 16'h55C3, 0);
        rdc(16'h0101, 1, 16'h0055, 0);
        rdc(16'h0100, 1, 16'h00C3, 0);
    endtask
    task automatic t_unimpl;
        wr(16'h0800, 16'hFFFF, 0);
        wr(16'h8000, 16'hFFFF, 0);
        rdc(16'h0800, 0, 16'h0000, 0);
        rdc(16'h7FFF, 1, 16'h0000, 0);
        rdc(16'h0000, 0, 16'h1234, 0);
    endtask
    task automatic t_window;
        rdc(16'h8000, 0, 16'h25C3, 1);
        rdc(16'hFFFF, 1, 16'h003C, 1);
    endtask
    task automatic t_burst;
        @(negedge I_SYS_CLK) {re, ra, rb, we, wa, wd, wb} = {1'b1, 16'h0000, 1'b0, 1'b1, 16'h0000, 16'h7777, 1'b0};
        @(negedge I_SYS_CLK) {re, ra, we} = {1'b1, 16'h8002, 1'b0};
        @(negedge I_SYS_CLK) re = 0;
        `CHK("burst valid 1", 1'b1, rv)
        `CHK("burst old word", 16'h1234, rd)
        `CHK("burst window", 1'b1, pe)
        @(negedge I_SYS_CLK);
        `CHK("burst valid 2", 1'b1, rv)
        `CHK("burst window data", 16'h25C1, rd)
        rdc(16'h0000, 0, 16'h7777, 0);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        close_out;
    end
    initial
    begin
        repeat (6) @(negedge I_SYS_CLK);
        I_RESET_N = 1;
        t_words;
        t_lanes;
        t_unimpl;
        t_window;
        t_burst;
        close_out;
    end
endmodule
`default_nettype wire
